// ==== logic/ptw_pkg.sv ====
// package: constants and types of the target window translation block
package ptw_pkg;
   // ------------------------------------------------------------
   // pci command codes (c_be_l during the address phase)
   // ------------------------------------------------------------
   localparam logic [3:0] CMD_MEM_READ      = 4'h6;
   localparam logic [3:0] CMD_MEM_WRITE     = 4'h7;
   localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
   localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
   localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hf;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_WBASE0  = 8'h00;
   localparam logic [7:0] OFS_WMASK0  = 8'h04;
   localparam logic [7:0] OFS_TBASE0  = 8'h08;
   localparam logic [7:0] OFS_WBASE1  = 8'h0c;
   localparam logic [7:0] OFS_WMASK1  = 8'h10;
   localparam logic [7:0] OFS_TBASE1  = 8'h14;
   localparam logic [7:0] OFS_ERRSTAT = 8'h18;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int WBASE_WEN_BIT  = 0;
   localparam int WBASE_SG_BIT   = 1;
   localparam int ERR_ERR_BIT    = 0;
   localparam int ERR_LOST_BIT   = 1;
   localparam int ERR_CODE_LSB   = 2;
   localparam int PTE_VALID_BIT  = 0;
   localparam int PTE_PAGE_LSB   = 1;
   localparam logic [31:0] WIN_RESET = 32'h0000_0000;
   localparam logic [2:0] CODE_INVALID_PAGE = 3'h6;
   localparam logic [2:0] CODE_NO_DECODE    = 3'h4;

   // ------------------------------------------------------------
   // target state machine
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0000,
      ST_DECODE = 4'b0001,
      ST_XLATE  = 4'b0010,
      ST_FETCH  = 4'b0011,
      ST_MEM    = 4'b0100,
      ST_DATA   = 4'b0101,
      ST_ABORT  = 4'b0110,
      ST_TURN   = 4'b0111,
      ST_WAIT   = 4'b1000
   } ptw_state_e;
endpackage

// ==== logic/ptw_target.sv ====
// module: pci target front end, window decode and address translation
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
// Operation
// - accept memory read and memory write commands natively.
// - read multiple and read line act as read; write-invalidate as write.
// - ignore all other commands: no device select at all.
// - two independent windows, each with base, size mask, translated base.
// - size mask covers address bits 31..20, sizes 1 MB to 4 GB.
// - hit when masked xor of address and base is all zero.
// - only hits in enabled windows are answered.
// - claim with device select and translate to a 34-bit address.
// - scatter-gather select picks table lookup, else direct translation.
// - direct: translated base above window, pci bits inside, top bits zero.
// - entry address: translated base, pci bits 13 and up, three zeros.
// - each entry is one quadword mapping one 8 KB page.
// - final address: entry page bits joined with pci bits 12..0.
// - invalid entry: log error, raise interrupt, end transfer.
// - address not decoded by memory: log, interrupt, target abort, except the data write of a write transfer, which has already finished.
// - device select comes two cycles after frame.
// - invalid entry: abort reads, finish writes but drop the data.
// - invalid entry logs code six and page number unless error latched.
module ptw_target
   import ptw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // register bus
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // pci pins
   input  wire logic        pciClk,
   input  wire logic        frameN,
   input  wire logic        irdyN,
   input  wire logic [3:0]  cbeN,
   input  wire logic [31:0] adIn,
   output logic [31:0]      adOut,
   output logic             adOe,
   output logic             devselN,
   output logic             trdyN,
   output logic             stopN,
   output logic             targetOe,
   // memory controller
   output logic             memReq,
   output logic             memWrite,
   output logic [33:0]      memAddr,
   output logic [31:0]      memWdata,
   input  wire logic        memAck,
   input  wire logic        memNoDecode,
   input  wire logic [63:0] memRdata,
   // internal error interrupt to the cpu
   output logic             errIrq
);
   // ------------------------------------------------------------
   // pin synchronisers and pci clock edge detect
   // ------------------------------------------------------------
   logic [1:0]  clkSync_reg;
   logic        clkPrev_reg;
   logic [37:0] pinS1_reg;
   logic [37:0] pinS2_reg;
   logic [37:0] pinLat_reg;

   // first stage is read only by the second
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         clkSync_reg <= 2'b00;
         clkPrev_reg <= 1'b0;
         pinS1_reg   <= {38{1'b1}};
         pinS2_reg   <= {38{1'b1}};
      end else begin
         clkSync_reg <= {clkSync_reg[0], pciClk};
         clkPrev_reg <= clkSync_reg[1];
         pinS1_reg   <= {frameN, irdyN, cbeN, adIn};
         pinS2_reg   <= pinS1_reg;
      end
   end

   wire pciRise = clkSync_reg[1] & ~clkPrev_reg;
   wire pciFall = ~clkSync_reg[1] & clkPrev_reg;

   // pins are caught mid-cycle, far from the edge where they move
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pinLat_reg <= {38{1'b1}};
      end else if (pciFall) begin
         pinLat_reg <= pinS2_reg;
      end
   end

   wire        frameLow = ~pinLat_reg[37];
   wire        irdyLow  = ~pinLat_reg[36];
   wire [3:0]  cmdPin   = pinLat_reg[35:32];
   wire [31:0] adPin    = pinLat_reg[31:0];

   // ------------------------------------------------------------
   // register file and avalon slave
   // ------------------------------------------------------------
   logic [31:0] winBase_reg [2];
   logic [31:0] winMask_reg [2];
   logic [31:0] xlatBase_reg [2];
   logic        errFlag_reg;
   logic        lostFlag_reg;
   logic [2:0]  errCode_reg;
   logic [18:0] failPage_reg;
   logic        busDone_reg;
   logic [31:0] readData_reg;

   // byte lane merge, used for every writable word but the error status word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // one wait cycle on every access, then the answer stands
   wire busReq   = avs_read | avs_write;
   wire wrTake   = avs_write & busDone_reg;
   wire clrErr   = wrTake & avs_byteenable[0] & avs_writedata[ERR_ERR_BIT];
   wire clrLost  = wrTake & avs_byteenable[0] & avs_writedata[ERR_LOST_BIT];
   wire [31:0] errWord = {failPage_reg, 8'h00, errCode_reg, lostFlag_reg, errFlag_reg};
   assign avs_waitrequest = busReq & ~busDone_reg;
   assign avs_readdata    = readData_reg;

   logic [31:0] readMux;
   always_comb begin
      case (avs_address)
         OFS_WBASE0:  readMux = winBase_reg[0];
         OFS_WMASK0:  readMux = winMask_reg[0];
         OFS_TBASE0:  readMux = xlatBase_reg[0];
         OFS_WBASE1:  readMux = winBase_reg[1];
         OFS_WMASK1:  readMux = winMask_reg[1];
         OFS_TBASE1:  readMux = xlatBase_reg[1];
         OFS_ERRSTAT: readMux = errWord;
         default:     readMux = 32'h0000_0000;
      endcase
   end

   // bus handshake and read data
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busDone_reg  <= 1'b0;
         readData_reg <= 32'h0000_0000;
      end else begin
         busDone_reg  <= busReq & ~busDone_reg;
         readData_reg <= readMux;
      end
   end

   // ------------------------------------------------------------
   // the two windows
   // ------------------------------------------------------------
   ptw_win_if winBus [2] ();
   logic [1:0]  winHit;
   logic [1:0]  winSg;
   logic [31:0] winDirect [2];
   logic [31:0] winEntry [2];
   logic [31:0] addr_reg;

   for (genvar g = 0; g < 2; g++) begin : g_win
      wire [7:0] ofsB = (g == 0) ? OFS_WBASE0 : OFS_WBASE1;
      wire [7:0] ofsM = (g == 0) ? OFS_WMASK0 : OFS_WMASK1;
      wire [7:0] ofsT = (g == 0) ? OFS_TBASE0 : OFS_TBASE1;

      // window settings written by software
      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            winBase_reg[g]  <= WIN_RESET;
            winMask_reg[g]  <= WIN_RESET;
            xlatBase_reg[g] <= WIN_RESET;
         end else if (wrTake) begin
            if (avs_address == ofsB) begin
               winBase_reg[g] <= merge(winBase_reg[g], avs_writedata, avs_byteenable);
            end
            if (avs_address == ofsM) begin
               winMask_reg[g] <= merge(winMask_reg[g], avs_writedata, avs_byteenable);
            end
            if (avs_address == ofsT) begin
               xlatBase_reg[g] <= merge(xlatBase_reg[g], avs_writedata, avs_byteenable);
            end
         end
      end

      assign winBus[g].winBase  = winBase_reg[g];
      assign winBus[g].winMask  = winMask_reg[g];
      assign winBus[g].xlatBase = xlatBase_reg[g];
      assign winBus[g].pciAddr  = addr_reg;
      assign winHit[g]    = winBus[g].hit;
      assign winSg[g]     = winBus[g].sgSel;
      assign winDirect[g] = winBus[g].directAddr;
      assign winEntry[g]  = winBus[g].entryAddr;

      ptw_window u_win (
         .w (winBus[g])
      );
   end

   // ------------------------------------------------------------
   // command and window selection
   // ------------------------------------------------------------
   logic [3:0] cmd_reg;
   wire isRead  = (cmd_reg == CMD_MEM_READ) | (cmd_reg == CMD_MEM_READ_MULT)
                | (cmd_reg == CMD_MEM_READ_LINE);
   wire isWrite = (cmd_reg == CMD_MEM_WRITE) | (cmd_reg == CMD_MEM_WRITE_INV);
   wire cmdOk   = isRead | isWrite;
   wire anyHit  = |winHit;
   wire selWin  = ~winHit[0];
   wire selSg   = winSg[selWin];
   wire pteValid = memRdata[PTE_VALID_BIT];
   wire [18:0] ptePage = memRdata[PTE_PAGE_LSB +: 19];

   // ------------------------------------------------------------
   // target sequencer
   // ------------------------------------------------------------
   ptw_state_e state_reg, state_next;
   logic        write_reg;
   logic        discard_reg;
   logic [33:0] cpuAddr_reg;
   logic [31:0] data_reg;
   logic        logEvt;
   logic [2:0]  logCode;
   logic        selSg_reg;
   logic        selWin_reg;

   always_comb begin
      state_next = state_reg;
      logEvt     = 1'b0;
      logCode    = CODE_INVALID_PAGE;
      case (state_reg)
         ST_IDLE: begin
            if (pciRise & frameLow) begin
               state_next = ST_DECODE;
            end
         end
         ST_DECODE: begin
            // decoded in the cycle after the address; claim on the next edge
            if (pciRise) begin
               state_next = (cmdOk & anyHit) ? ST_XLATE : ST_WAIT;
            end
         end
         ST_XLATE: begin
            if (selSg_reg) begin
               state_next = ST_FETCH;
            end else begin
               state_next = write_reg ? ST_DATA : ST_MEM;
            end
         end
         ST_FETCH: begin
            if (memNoDecode) begin
               logEvt     = 1'b1;
               logCode    = CODE_NO_DECODE;
               state_next = ST_ABORT;
            end else if (memAck & ~pteValid) begin
               logEvt     = 1'b1;
               state_next = write_reg ? ST_DATA : ST_ABORT;
            end else if (memAck) begin
               state_next = write_reg ? ST_DATA : ST_MEM;
            end
         end
         ST_MEM: begin
            if (memNoDecode) begin
               logEvt     = 1'b1;
               logCode    = CODE_NO_DECODE;
               state_next = write_reg ? ST_IDLE : ST_ABORT;
            end else if (memAck) begin
               state_next = write_reg ? ST_IDLE : ST_DATA;
            end
         end
         ST_DATA: begin
            if (pciRise & irdyLow & ~trdyN) begin
               state_next = ST_TURN;
            end
         end
         ST_ABORT: begin
            // stop must be shown for a pci cycle even when frame is already high
            if (pciRise & ~frameLow & ~stopN) begin
               state_next = ST_TURN;
            end
         end
         ST_TURN: begin
            if (pciRise) begin
               state_next = (write_reg & ~discard_reg) ? ST_MEM : ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (pciRise & ~frameLow) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // address capture, translation and transfer bookkeeping
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg   <= ST_IDLE;
         addr_reg    <= 32'h0000_0000;
         cmd_reg     <= 4'h0;
         write_reg   <= 1'b0;
         discard_reg <= 1'b0;
         selSg_reg   <= 1'b0;
         selWin_reg  <= 1'b0;
         cpuAddr_reg <= 34'h0_0000_0000;
         data_reg    <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
         if (state_reg == ST_IDLE && state_next == ST_DECODE) begin
            addr_reg    <= adPin;
            cmd_reg     <= cmdPin;
            discard_reg <= 1'b0;
         end
         if (state_reg == ST_DECODE) begin
            write_reg  <= isWrite;
            selSg_reg  <= selSg;
            selWin_reg <= selWin;
         end
         if (state_reg == ST_XLATE) begin
            cpuAddr_reg <= selSg_reg ? {2'b00, winEntry[selWin_reg]}
                                     : {2'b00, winDirect[selWin_reg]};
         end
         if (state_reg == ST_FETCH && memAck) begin
            cpuAddr_reg <= {2'b00, ptePage, addr_reg[12:0]};
            discard_reg <= ~pteValid;
         end
         if (state_reg == ST_MEM && memAck && !write_reg) begin
            data_reg <= memRdata[31:0];
         end
         if (state_reg == ST_DATA && state_next == ST_TURN && write_reg) begin
            data_reg <= adPin;
         end
      end
   end

   // memory request, held until the controller answers
   assign memReq   = (state_reg == ST_FETCH) | (state_reg == ST_MEM);
   assign memWrite = (state_reg == ST_MEM) & write_reg;
   assign memAddr  = cpuAddr_reg;
   assign memWdata = data_reg;

   // ------------------------------------------------------------
   // pci target pins, moved just after a pci rising edge; device select also drops on entering abort
   // ------------------------------------------------------------
   logic devsel_reg;
   logic trdy_reg;
   logic stop_reg;
   logic tOe_reg;
   logic adOe_reg;
   wire  claimed = (state_reg == ST_XLATE) | (state_reg == ST_FETCH)
                 | (state_reg == ST_MEM) | (state_reg == ST_DATA);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         devsel_reg <= 1'b0;
         trdy_reg   <= 1'b0;
         stop_reg   <= 1'b0;
         tOe_reg    <= 1'b0;
         adOe_reg   <= 1'b0;
      end else if (pciRise) begin
         devsel_reg <= claimed | (state_next == ST_XLATE);
         // single data phase, then disconnect
         trdy_reg   <= (state_reg == ST_DATA) & (state_next == ST_DATA);
         stop_reg   <= ((state_reg == ST_DATA) & (state_next == ST_DATA))
                     | ((state_reg == ST_ABORT) & (state_next == ST_ABORT));
         tOe_reg    <= (state_next != ST_IDLE) & (state_next != ST_DECODE)
                     & (state_next != ST_WAIT) & ~(state_reg == ST_WAIT);
         adOe_reg   <= (state_reg == ST_DATA) & (state_next == ST_DATA) & ~write_reg;
      end
   end

   // abort: device select dropped while stop is held
   assign devselN  = ~(devsel_reg & (state_reg != ST_ABORT));
   assign trdyN    = ~trdy_reg;
   assign stopN    = ~stop_reg;
   assign targetOe = tOe_reg;
   assign adOut    = data_reg;
   assign adOe     = adOe_reg;

   // ------------------------------------------------------------
   // error log: first error frozen, later ones only mark lost
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         errFlag_reg  <= 1'b0;
         lostFlag_reg <= 1'b0;
         errCode_reg  <= 3'h0;
         failPage_reg <= 19'h0_0000;
      end else begin
         // a new error beats a clear in the same cycle
         if (logEvt && !errFlag_reg) begin
            errFlag_reg  <= 1'b1;
            errCode_reg  <= logCode;
            failPage_reg <= addr_reg[31:13];
         end else if (clrErr && !logEvt) begin
            errFlag_reg  <= 1'b0;
         end
         if (logEvt && errFlag_reg) begin
            lostFlag_reg <= 1'b1;
         end else if (clrLost) begin
            lostFlag_reg <= 1'b0;
         end
      end
   end

   assign errIrq = errFlag_reg;
endmodule

// ==== logic/ptw_win_if.sv ====
// interface: one target window's settings, the address in, and its decode out
`timescale 1ns/1ns
interface ptw_win_if;
   logic [31:0] winBase;
   logic [31:0] winMask;
   logic [31:0] xlatBase;
   logic [31:0] pciAddr;
   logic        hit;
   logic        sgSel;
   logic [31:0] directAddr;
   logic [31:0] entryAddr;
   modport ctrl (output winBase, output winMask, output xlatBase, output pciAddr,
                 input hit, input sgSel, input directAddr, input entryAddr);
   modport win  (input winBase, input winMask, input xlatBase, input pciAddr,
                 output hit, output sgSel, output directAddr, output entryAddr);
endinterface

// ==== logic/ptw_window.sv ====
// module: hit test and address forming for one target window
`timescale 1ns/1ns
module ptw_window
   import ptw_pkg::*;
(
   ptw_win_if.win w
);
   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire [11:0] baseHi  = w.winBase[31:20];
   wire [11:0] maskHi  = w.winMask[31:20];
   wire [11:0] addrHi  = w.pciAddr[31:20];
   wire [11:0] missVec = (addrHi ^ baseHi) & ~maskHi;

   // non-contiguous masks still decode, but with no promise of sense
   assign w.hit   = w.winBase[WBASE_WEN_BIT] & ~(|missVec);
   assign w.sgSel = w.winBase[WBASE_SG_BIT];

   // direct: base above the window size, pci bits inside it
   assign w.directAddr = {(w.xlatBase[31:20] & ~maskHi) | (addrHi & maskHi),
                          w.pciAddr[19:0]};
   // map entry: quadword aligned, index from pci bit 13 to window top
   assign w.entryAddr  = {w.xlatBase[31:22],
                          w.xlatBase[21:10] | (addrHi & maskHi),
                          w.pciAddr[19:13], 3'b000};
endmodule

// ==== tb/ptw_mem_model.sv ====
// partner: memory controller answering translated requests after a set latency
`timescale 1ns/1ns
module ptw_mem_model (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        memReq,
   input  wire logic        noDecode,
   input  wire logic [3:0]  lat,
   input  wire logic [63:0] pteWord,
   output logic             memAck,
   output logic             memNoDecode,
   output logic [63:0]      memRdata
);
   logic [3:0] waitCnt_reg;
   // one pulse per request; data toggles outside it so stale values never match
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         waitCnt_reg <= 4'h0;
         memAck <= 1'b0;
         memNoDecode <= 1'b0;
         memRdata <= 64'h0;
      end else begin
         memAck <= 1'b0;
         memNoDecode <= 1'b0;
         memRdata <= ~memRdata;
         waitCnt_reg <= 4'h0;
         if (memReq && !memAck && !memNoDecode && waitCnt_reg < lat)
            waitCnt_reg <= waitCnt_reg + 4'h1;
         else if (memReq && !memAck && !memNoDecode) begin
            memAck <= !noDecode;
            memNoDecode <= noDecode;
            memRdata <= pteWord;
         end
      end
   end
endmodule

// ==== tb/ptw_target_asserts.sv ====
// checker: port assertions of the pci target window translation block
`timescale 1ns/1ns
module ptw_target_asserts
   import ptw_pkg::*;
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic        devselN,
   input wire logic        trdyN,
   input wire logic        stopN,
   input wire logic        targetOe,
   input wire logic        memReq,
   input wire logic [33:0] memAddr,
   input wire logic        memAck,
   input wire logic        memNoDecode,
   input wire logic        errIrq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // a memory request: still waiting, then still asking the same address
   sequence memWaiting; memReq && !memAck && !memNoDecode; endsequence
   sequence memHolding; memReq && $stable(memAddr); endsequence
   // bus answers, pin pairing, address form and error logging
   a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held past one cycle");
   a_mem_hold: assert property (memWaiting |=> memHolding)
      else $error("memory request dropped or moved");
   a_addr_top: assert property (memReq |-> memAddr[33:32] == 2'b00)
      else $error("translated address top bits not zero");
   a_claim_oe: assert property (!devselN |-> targetOe)
      else $error("device select low while not driven");
   a_stop_trdy: assert property (!trdyN |-> !stopN)
      else $error("ready without disconnect");
   a_abort_nodata: assert property (!stopN && devselN |-> trdyN)
      else $error("data phase during target abort");
   a_nodec_irq: assert property (memReq && memNoDecode |-> ##[1:3] errIrq)
      else $error("no interrupt after undecoded address");
   a_irq_clear: assert property ($fell(errIrq) |-> $past(avs_write))
      else $error("interrupt dropped without a clear");
endmodule
bind ptw_target ptw_target_asserts chk (.clk, .sys_rst, .avs_read, .avs_write, .avs_waitrequest,
   .devselN, .trdyN, .stopN, .targetOe, .memReq, .memAddr, .memAck, .memNoDecode, .errIrq);

// ==== tb/tb_top.sv ====
// testbench: command decode, window hits, translation and error logging
`timescale 1ns/1ns
module tb_top;
   import ptw_pkg::*;
   logic        clk = 0, sys_rst = 1, pciClk = 0, frameN = 1, irdyN = 1, mq = 0;
   logic        avs_read = 0, avs_write = 0, noDecode = 0;
   logic [7:0]  avs_address = 0;
   logic [3:0]  cbeN = 0, avs_byteenable = 0, lat = 0;
   logic [18:0] p, pg;
   logic [31:0] avs_writedata = 0, adIn = 0, avs_readdata, rd, a, adOut, memWdata;
   logic [63:0] pteWord = 0, memRdata;
   logic [33:0] memAddr;
   logic [34:0] expQ[$];
   logic        avs_waitrequest, devselN, trdyN, stopN, memReq, memAck, memNoDecode, errIrq;
   logic        memWrite;
   int          n_mismatch = 0, tests_run = 0, seed = 81698, k, dev, abt;
   ptw_target uut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .pciClk, .frameN, .irdyN, .cbeN, .adIn,
      .adOut, .adOe(), .devselN, .trdyN, .stopN, .targetOe(), .memReq, .memWrite, .memAddr,
      .memWdata, .memAck, .memNoDecode, .memRdata, .errIrq);
   ptw_mem_model mem (.clk, .sys_rst, .memReq, .noDecode, .lat, .pteWord, .memAck,
      .memNoDecode, .memRdata);
   // unrelated clocks: 10 ns system, 80 ns pci with an offset
   initial forever #5 clk = ~clk;
   initial begin
      #3;
      forever #40 pciClk = ~pciClk;
   end
   task automatic cmp(string nm, logic [34:0] e, logic [34:0] s);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(logic w, logic [7:0] ad, logic [31:0] d, logic [3:0] be);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= ad;
      avs_writedata <= d;
      avs_byteenable <= be;
      @(posedge clk);
      while (avs_waitrequest) @(posedge clk);
      rd = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
      @(posedge clk);
   endtask
   // single data phase; pins sampled mid pci cycle where they have settled
   task automatic pci(logic [3:0] cmd, logic [31:0] ad);
      @(posedge pciClk);
      @(posedge clk);
      frameN <= 0;
      cbeN <= cmd;
      adIn <= ad;
      @(posedge pciClk);
      @(posedge clk);
      frameN <= 1;
      irdyN <= 0;
      adIn <= ~ad;
      dev = 0;
      for (k = 1; k < 40; k++) begin
         @(negedge pciClk);
         if (!devselN && !dev) dev = k;
         abt = !stopN && devselN;
         if (!trdyN || abt || (k > 4 && !dev)) break;
      end
      @(posedge pciClk);
      @(posedge clk);
      irdyN <= 1;
      repeat (3) @(posedge pciClk);
      @(posedge clk);
   endtask
   task automatic complete_run;
      if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // each new memory request takes the oldest noted address
   always @(posedge clk) begin
      if (memReq && !mq)
         cmp("memAddr", expQ.size() ? expQ.pop_front() : '1, {memWrite, memAddr});
      mq <= memReq && !memAck && !memNoDecode;
   end
   // window 0 direct 1 MB, window 1 table lookup 4 MB (disabled first)
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 0;
      repeat (3) @(posedge clk);
      bus(1, OFS_WBASE0, 32'h1000_0001, 4'hf);
      bus(1, OFS_TBASE0, 32'h0230_0000, 4'hf);
      bus(1, OFS_WBASE1, 32'h8000_0002, 4'hf);
      bus(1, OFS_WMASK1, 32'h0030_0000, 4'hf);
      bus(1, OFS_TBASE1, 32'h0040_0000, 4'hf);
      bus(0, OFS_WMASK1, 0, 0);
      cmp("wmask1", 32'h0030_0000, rd);
      bus(0, 8'hfc, 0, 0);
      cmp("unmapped", 0, rd);
      for (int c = 0; c < 16; c++) begin
         a = {12'h100, 18'($random(seed)), 2'b00};
         if (c inside {6, 7, 12, 14, 15}) expQ.push_back({c[0], 14'h0023, a[19:0]});
         pci(c[3:0], a);
         cmp("claim", (c inside {6, 7, 12, 14, 15}) ? 2 : 0, dev);
      end
      pci(CMD_MEM_READ, 32'h8012_0000);
      cmp("disabled", 0, dev);
      bus(1, OFS_WBASE1, 32'h8000_0003, 4'hf);
      // valid read and write, then invalid read and invalid write
      for (int i = 0; i < 4; i++) begin
         a = {10'h200, 20'($random(seed)), 2'b00};
         p = 19'($random(seed));
         if (i == 2) pg = a[31:13];
         pteWord <= {44'h0, p, i < 2};
         lat <= 4'(i * 3);
         expQ.push_back({3'b000, 20'h00400, a[21:13], 3'b000});
         if (i < 2) expQ.push_back({i[0], 2'b00, p, a[12:0]});
         pci(CMD_MEM_READ | 4'(i % 2), a);
         cmp("claim sg", 2, dev);
         cmp("abort", i == 2, abt);
         if (i == 0) cmp("adOut", {12'h000, p, 1'b1}, adOut);
         if (i == 1) cmp("memWdata", {3'b000, ~a}, memWdata);
      end
      bus(0, OFS_ERRSTAT, 0, 0);
      cmp("errword", {pg, 8'h00, 3'h6, 2'b11}, rd);
      cmp("irq", 1, errIrq);
      bus(1, OFS_ERRSTAT, 32'h3, 4'h1);
      cmp("irq clear", 0, errIrq);
      noDecode <= 1;
      expQ.push_back({3'b000, 12'h023, 20'h00040});
      pci(CMD_MEM_READ_LINE, 32'h1000_0040);
      cmp("nodecode abort", 1, abt);
      cmp("nodecode irq", 1, errIrq);
      cmp("pending", 0, expQ.size());
      complete_run;
   end
   // cut a hang short
   initial begin
      #500000;
      n_mismatch++;
      complete_run;
   end
endmodule
